// ### src/pbm_pkg.sv
// constants for the port-b pin function mux
// assumes a 32-bit classic wishbone register bus with byte addresses
package pbm_pkg;
    localparam int NPIN    = 11;
    localparam int NOPT    = 4;
    localparam int SEL_W   = 2;
    localparam int LOW_NP  = 6;
    localparam int HIGH_NP = 5;
    // register byte offsets
    localparam logic [3:0] ADR_LOW   = 4'h0;
    localparam logic [3:0] ADR_HIGH  = 4'h4;
    localparam logic [3:0] ADR_LEVEL = 4'h8;
    // field placement inside the select registers
    localparam int LOW_LSB  = 0;
    localparam int HIGH_LSB = 22;
    localparam logic [31:0] LOW_MASK  = 32'h00000FFF;
    localparam logic [31:0] HIGH_MASK = 32'hFFC00000;
    localparam logic [31:0] LOW_RST   = 32'h00000000;
    localparam logic [31:0] HIGH_RST  = 32'h00000000;
    // select codes
    localparam logic [1:0] SEL_GPIO = 2'h0;
    localparam logic [1:0] SEL_ALT1 = 2'h1;
    localparam logic [1:0] SEL_ALT2 = 2'h2;
    localparam logic [1:0] SEL_ALT3 = 2'h3;
    // pad index of each pin except 60 and 61, which sit at P59+1 and P59+2
    localparam int P32 = 0;
    localparam int P33 = 1;
    localparam int P34 = 2;
    localparam int P35 = 3;
    localparam int P36 = 4;
    localparam int P37 = 5;
    localparam int P59 = 6;
    localparam int P62 = 9;
    localparam int P63 = 10;
    // level fed to each input consumer while its option is not selected
    localparam logic [3:0] IDLE_LVL [NPIN] = '{4'h2, 4'h2, 4'hC, 4'h0, 4'h2, 4'h0,
                                               4'h0, 4'h0, 4'h0, 4'h2, 4'h0};
endpackage

// ### src/pbm_cfg_if.sv
// select fields and pad levels passed between register file and mux core
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface pbm_cfg_if;
    logic [pbm_pkg::SEL_W*pbm_pkg::NPIN-1:0] sel;
    logic [pbm_pkg::NPIN-1:0]                level;
    modport regs (output sel, input level);
    modport core (input sel, output level);
endinterface

// ### src/pbm_wb_regs.sv
// wishbone classic slave holding the two select registers and a level view
// assumes single-cycle classic requests held until ack
`timescale 1ns/1ps
module pbm_wb_regs #(
    parameter int ADR_W = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    // wishbone slave
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic             wb_we_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o,
    // toward the mux core
    pbm_cfg_if.regs               cfg
);
    if (ADR_W < 4)
    begin : g_chk
        $error("pbm_wb_regs: ADR_W must be at least 4");
    end

    typedef struct packed {
        logic        ack;
        logic [31:0] low;
        logic [31:0] high;
        logic [31:0] dat;
    } pbm_regs_s;

    pbm_regs_s st_reg;
    pbm_regs_s st_next;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
        return (old & ~m) | (wd & m);
    endfunction

    logic       req;
    logic       hit_hi;
    logic [3:0] off;

    always_comb
    begin
        st_next = st_reg;
        req     = wb_cyc_i && wb_stb_i && !st_reg.ack;
        hit_hi  = (wb_adr_i >> 4) != '0;
        off     = wb_adr_i[3:0];
        st_next.ack = req;
        if (req)
        begin
            // unmapped offsets answer with zero and ignore writes
            st_next.dat = 32'h00000000;
            if (!hit_hi && off == pbm_pkg::ADR_LOW)
            begin
                st_next.dat = st_reg.low;
                if (wb_we_i)
                    st_next.low = merge(st_reg.low, wb_dat_i, wb_sel_i, pbm_pkg::LOW_MASK);
            end
            if (!hit_hi && off == pbm_pkg::ADR_HIGH)
            begin
                st_next.dat = st_reg.high;
                if (wb_we_i)
                    st_next.high = merge(st_reg.high, wb_dat_i, wb_sel_i, pbm_pkg::HIGH_MASK);
            end
            if (!hit_hi && off == pbm_pkg::ADR_LEVEL)
                st_next.dat = {{(32 - pbm_pkg::NPIN){1'b0}}, cfg.level};
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            st_reg <= '{ack: 1'b0, low: pbm_pkg::LOW_RST, high: pbm_pkg::HIGH_RST, dat: 32'h00000000};
        else if (clk_en)
            st_reg <= st_next;
    end

    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.dat;
    assign cfg.sel  = {st_reg.high[31:pbm_pkg::HIGH_LSB], st_reg.low[pbm_pkg::LOW_LSB +: 2*pbm_pkg::LOW_NP]};
endmodule

// ### src/pbm_pin_cell.sv
// one pad: four-way selection of output, enable and input routing
// assumes the caller supplies the four options per pad
`timescale 1ns/1ps
module pbm_pin_cell #(
    parameter logic [3:0] IDLE = 4'h0
) (
    // selection
    input  wire logic [1:0] sel,
    // candidate drivers
    input  wire logic [3:0] opt_out,
    input  wire logic [3:0] opt_oe,
    // pad side
    input  wire logic       pad_in,
    output logic            pad_out,
    output logic            pad_oe,
    // per-option input view
    output logic [3:0]      route_in
);
    always_comb
    begin
        pad_out = opt_out[sel];
        pad_oe  = opt_oe[sel];
        for (int k = 0; k < 4; k++)
            route_in[k] = (sel == k[1:0]) ? pad_in : IDLE[k];
    end
endmodule

// ### src/pbm_top.sv
// port-b pin function mux: register file plus per-pad option routing
// assumes peripherals and pads run on clk; pad drive is registered one cycle
//
// Overview of operation
// - pin37 field 11:10 selects gpio, capture unit 2, or zone 7 chip select.
// - pin36 field 9:8 selects gpio, serial A receive, or zone 0 chip select.
// - pin35 field 7:6 selects gpio, serial A transmit, or read/not-write strobe.
// - read/not-write rests high, low during external writes, high during reads.
// - pin34 field 5:4 selects gpio, capture unit 1, or external ready input.
// - pin33 field 3:2 selects gpio, i2c clock, pwm sync out, adc start B.
// - pin32 field 1:0 selects gpio, i2c data, pwm sync in, adc start A.
// - pin63 field 31:30 selects gpio, serial C transmit, or data line 16.
// - pin62 field 29:28 selects gpio, serial C receive, or data line 17.
// - pin61 field 27:26 selects gpio, port B frame sync, or data line 18.
// - pin60 field 25:24 selects gpio, port B receive clock, or data line 19.
// - pin59 field 23:22 selects gpio, port A frame sync, or data line 20.
// - all select fields are read/write and reset to zero, meaning gpio.
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
module pbm_top #(
    parameter int ADR_W = 4
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      clk_en,
    // wishbone slave
    input  wire logic [ADR_W-1:0]          wb_adr_i,
    input  wire logic [31:0]               wb_dat_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic                      wb_we_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    output logic [31:0]                    wb_dat_o,
    output logic                           wb_ack_o,
    // pads, index 0..5 = pins 32..37, 6..10 = pins 59..63
    input  wire logic [pbm_pkg::NPIN-1:0]  pad_in,
    output logic [pbm_pkg::NPIN-1:0]       pad_out,
    output logic [pbm_pkg::NPIN-1:0]       pad_oe,
    // general purpose i/o block
    input  wire logic [pbm_pkg::NPIN-1:0]  gpio_out,
    input  wire logic [pbm_pkg::NPIN-1:0]  gpio_oe,
    output logic [pbm_pkg::NPIN-1:0]       gpio_in,
    // capture units
    input  wire logic                      capture_unit_1_io_out,
    input  wire logic                      capture_unit_1_io_oe,
    output logic                           capture_unit_1_io_in,
    input  wire logic                      capture_unit_2_io_out,
    input  wire logic                      capture_unit_2_io_oe,
    output logic                           capture_unit_2_io_in,
    // serial interfaces
    input  wire logic                      serial_a_transmit,
    output logic                           serial_a_receive,
    input  wire logic                      serial_c_transmit,
    output logic                           serial_c_receive,
    // i2c, open drain
    input  wire logic                      i2c_clock_line_drive_low,
    output logic                           i2c_clock_line_in,
    input  wire logic                      i2c_data_line_drive_low,
    output logic                           i2c_data_line_in,
    // pwm sync and adc starts
    input  wire logic                      pwm_sync_out,
    output logic                           pwm_sync_in,
    input  wire logic                      adc_start_a_out,
    input  wire logic                      adc_start_b_out,
    // buffered serial ports
    input  wire logic                      bsp_a_rx_frame_sync_out,
    input  wire logic                      bsp_a_rx_frame_sync_oe,
    output logic                           bsp_a_rx_frame_sync_in,
    input  wire logic                      bsp_b_rx_frame_sync_out,
    input  wire logic                      bsp_b_rx_frame_sync_oe,
    output logic                           bsp_b_rx_frame_sync_in,
    input  wire logic                      bsp_b_rx_clock_out,
    input  wire logic                      bsp_b_rx_clock_oe,
    output logic                           bsp_b_rx_clock_in,
    // external memory interface, data bit 0 = line 16
    input  wire logic                      ext_zone0_chip_select,
    input  wire logic                      ext_zone7_chip_select,
    input  wire logic                      ext_write_cycle,
    output logic                           ext_ready_input,
    input  wire logic [4:0]                ext_data_line_out,
    input  wire logic [4:0]                ext_data_line_oe,
    output logic [4:0]                     ext_data_line_in
);
    localparam int N = pbm_pkg::NPIN;

    typedef struct packed {
        logic [N-1:0] pad_out;
        logic [N-1:0] pad_oe;
        logic [N-1:0] gpio_in;
        logic         cap1_in;
        logic         cap2_in;
        logic         ser_a_rx;
        logic         ser_c_rx;
        logic         scl_in;
        logic         sda_in;
        logic         sync_in;
        logic         fs_a_in;
        logic         fs_b_in;
        logic         clk_b_in;
        logic         ready_in;
        logic [4:0]   data_in;
        logic [N-1:0] pad_lvl;
    } pbm_core_s;

    // inputs come out of reset at their idle levels
    localparam pbm_core_s CORE_RST = '{
        pad_out:  '0,
        pad_oe:   '0,
        gpio_in:  '0,
        cap1_in:  1'b0,
        cap2_in:  1'b0,
        ser_a_rx: 1'b1,
        ser_c_rx: 1'b1,
        scl_in:   1'b1,
        sda_in:   1'b1,
        sync_in:  1'b0,
        fs_a_in:  1'b0,
        fs_b_in:  1'b0,
        clk_b_in: 1'b0,
        ready_in: 1'b1,
        data_in:  5'h00,
        pad_lvl:  '0
    };

    pbm_core_s st_reg;
    pbm_core_s st_next;

    pbm_cfg_if cfg ();

    pbm_wb_regs #(
        .ADR_W (ADR_W)
    ) u_regs (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .wb_adr_i (wb_adr_i),
        .wb_dat_i (wb_dat_i),
        .wb_sel_i (wb_sel_i),
        .wb_we_i  (wb_we_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .cfg      (cfg)
    );

    // software sees the pad levels as the mux last sampled them
    assign cfg.level = st_reg.pad_lvl;

    logic [N-1:0][3:0] opt_out;
    logic [N-1:0][3:0] opt_oe;
    logic [N-1:0][3:0] route;
    logic [N-1:0]      cell_out;
    logic [N-1:0]      cell_oe;

    // option table per pad: 0 gpio, 1..3 alternates
    always_comb
    begin
        opt_out = '0;
        opt_oe  = '0;
        for (int i = 0; i < N; i++)
        begin
            opt_out[i][0] = gpio_out[i];
            opt_oe[i][0]  = gpio_oe[i];
        end
        // pin 32: open drain only ever pulls low
        opt_oe[pbm_pkg::P32][1]  = i2c_data_line_drive_low;
        opt_out[pbm_pkg::P32][3] = adc_start_a_out;
        opt_oe[pbm_pkg::P32][3]  = 1'b1;
        // pin 33
        opt_oe[pbm_pkg::P33][1]  = i2c_clock_line_drive_low;
        opt_out[pbm_pkg::P33][2] = pwm_sync_out;
        opt_oe[pbm_pkg::P33][2]  = 1'b1;
        opt_out[pbm_pkg::P33][3] = adc_start_b_out;
        opt_oe[pbm_pkg::P33][3]  = 1'b1;
        // pin 34: ready is input only
        opt_out[pbm_pkg::P34][1] = capture_unit_1_io_out;
        opt_oe[pbm_pkg::P34][1]  = capture_unit_1_io_oe;
        // pin 35: strobe low only while a write cycle runs
        opt_out[pbm_pkg::P35][1] = serial_a_transmit;
        opt_oe[pbm_pkg::P35][1]  = 1'b1;
        opt_out[pbm_pkg::P35][2] = ~ext_write_cycle;
        opt_out[pbm_pkg::P35][3] = ~ext_write_cycle;
        opt_oe[pbm_pkg::P35][2]  = 1'b1;
        opt_oe[pbm_pkg::P35][3]  = 1'b1;
        // pin 36: receive data is input only
        opt_out[pbm_pkg::P36][2] = ext_zone0_chip_select;
        opt_out[pbm_pkg::P36][3] = ext_zone0_chip_select;
        opt_oe[pbm_pkg::P36][2]  = 1'b1;
        opt_oe[pbm_pkg::P36][3]  = 1'b1;
        // pin 37
        opt_out[pbm_pkg::P37][1] = capture_unit_2_io_out;
        opt_oe[pbm_pkg::P37][1]  = capture_unit_2_io_oe;
        opt_out[pbm_pkg::P37][2] = ext_zone7_chip_select;
        opt_out[pbm_pkg::P37][3] = ext_zone7_chip_select;
        opt_oe[pbm_pkg::P37][2]  = 1'b1;
        opt_oe[pbm_pkg::P37][3]  = 1'b1;
        // pins 59..61: buffered serial port lines
        opt_out[pbm_pkg::P59][1]   = bsp_a_rx_frame_sync_out;
        opt_oe[pbm_pkg::P59][1]    = bsp_a_rx_frame_sync_oe;
        opt_out[pbm_pkg::P59+1][1] = bsp_b_rx_clock_out;
        opt_oe[pbm_pkg::P59+1][1]  = bsp_b_rx_clock_oe;
        opt_out[pbm_pkg::P59+2][1] = bsp_b_rx_frame_sync_out;
        opt_oe[pbm_pkg::P59+2][1]  = bsp_b_rx_frame_sync_oe;
        // pin 62 receive is input only; pin 63 transmits
        opt_out[pbm_pkg::P63][1] = serial_c_transmit;
        opt_oe[pbm_pkg::P63][1]  = 1'b1;
        // pins 59..63 carry data lines 20 down to 16 on codes 10 and 11
        for (int k = 0; k < pbm_pkg::HIGH_NP; k++)
        begin
            opt_out[pbm_pkg::P59+k][2] = ext_data_line_out[4-k];
            opt_out[pbm_pkg::P59+k][3] = ext_data_line_out[4-k];
            opt_oe[pbm_pkg::P59+k][2]  = ext_data_line_oe[4-k];
            opt_oe[pbm_pkg::P59+k][3]  = ext_data_line_oe[4-k];
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_pin
            pbm_pin_cell #(
                .IDLE (pbm_pkg::IDLE_LVL[g])
            ) u_cell (
                .sel      (cfg.sel[2*g +: 2]),
                .opt_out  (opt_out[g]),
                .opt_oe   (opt_oe[g]),
                .pad_in   (pad_in[g]),
                .pad_out  (cell_out[g]),
                .pad_oe   (cell_oe[g]),
                .route_in (route[g])
            );
        end
    endgenerate

    // codes 10 and 11 share a consumer: idle-high ones join by and, idle-low by or
    always_comb
    begin
        st_next          = st_reg;
        st_next.pad_lvl  = pad_in;
        st_next.pad_out  = cell_out;
        st_next.pad_oe   = cell_oe;
        for (int i = 0; i < N; i++)
            st_next.gpio_in[i] = route[i][0];
        st_next.sda_in   = route[pbm_pkg::P32][1];
        st_next.sync_in  = route[pbm_pkg::P32][2];
        st_next.scl_in   = route[pbm_pkg::P33][1];
        st_next.cap1_in  = route[pbm_pkg::P34][1];
        st_next.ready_in = route[pbm_pkg::P34][2] & route[pbm_pkg::P34][3];
        st_next.ser_a_rx = route[pbm_pkg::P36][1];
        st_next.cap2_in  = route[pbm_pkg::P37][1];
        st_next.fs_a_in  = route[pbm_pkg::P59][1];
        st_next.clk_b_in = route[pbm_pkg::P59+1][1];
        st_next.fs_b_in  = route[pbm_pkg::P59+2][1];
        st_next.ser_c_rx = route[pbm_pkg::P62][1];
        for (int k = 0; k < pbm_pkg::HIGH_NP; k++)
            st_next.data_in[4-k] = route[pbm_pkg::P59+k][2] | route[pbm_pkg::P59+k][3];
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            st_reg <= CORE_RST;
        else if (clk_en)
            st_reg <= st_next;
    end

    assign pad_out                 = st_reg.pad_out;
    assign pad_oe                  = st_reg.pad_oe;
    assign gpio_in                 = st_reg.gpio_in;
    assign capture_unit_1_io_in    = st_reg.cap1_in;
    assign capture_unit_2_io_in    = st_reg.cap2_in;
    assign serial_a_receive        = st_reg.ser_a_rx;
    assign serial_c_receive        = st_reg.ser_c_rx;
    assign i2c_clock_line_in       = st_reg.scl_in;
    assign i2c_data_line_in        = st_reg.sda_in;
    assign pwm_sync_in             = st_reg.sync_in;
    assign bsp_a_rx_frame_sync_in  = st_reg.fs_a_in;
    assign bsp_b_rx_frame_sync_in  = st_reg.fs_b_in;
    assign bsp_b_rx_clock_in       = st_reg.clk_b_in;
    assign ext_ready_input         = st_reg.ready_in;
    assign ext_data_line_in        = st_reg.data_in;
endmodule

// ### dv/pbm_periph_model.sv
// peripheral and gpio stand-in: every peripheral source follows one level from the bench, gpio its inverse
// assumes the bench changes lvl by non-blocking assignment after a clock edge
`timescale 1ns/1ps
module pbm_periph_model (
    // level chosen by the bench
    input  wire logic                      lvl,
    // gpio block, driven opposite so a wrong route shows
    output logic [pbm_pkg::NPIN-1:0]       gpio_out,
    output logic [pbm_pkg::NPIN-1:0]       gpio_oe,
    // peripheral sources
    output logic                           capture_unit_1_io_out, capture_unit_1_io_oe,
    output logic                           capture_unit_2_io_out, capture_unit_2_io_oe,
    output logic                           serial_a_transmit, serial_c_transmit,
    output logic                           i2c_clock_line_drive_low, i2c_data_line_drive_low,
    output logic                           pwm_sync_out, adc_start_a_out, adc_start_b_out,
    output logic                           bsp_a_rx_frame_sync_out, bsp_a_rx_frame_sync_oe,
    output logic                           bsp_b_rx_frame_sync_out, bsp_b_rx_frame_sync_oe,
    output logic                           bsp_b_rx_clock_out, bsp_b_rx_clock_oe,
    // external memory interface
    output logic                           ext_zone0_chip_select, ext_zone7_chip_select, ext_write_cycle,
    output logic [4:0]                     ext_data_line_out,
    output logic [4:0]                     ext_data_line_oe
);
    assign gpio_out = {pbm_pkg::NPIN{~lvl}};
    assign gpio_oe  = {pbm_pkg::NPIN{~lvl}};
    assign {capture_unit_1_io_out, capture_unit_1_io_oe, capture_unit_2_io_out, capture_unit_2_io_oe,
            serial_a_transmit, serial_c_transmit, i2c_clock_line_drive_low, i2c_data_line_drive_low,
            pwm_sync_out, adc_start_a_out, adc_start_b_out, bsp_a_rx_frame_sync_out, bsp_a_rx_frame_sync_oe,
            bsp_b_rx_frame_sync_out, bsp_b_rx_frame_sync_oe, bsp_b_rx_clock_out, bsp_b_rx_clock_oe,
            ext_zone0_chip_select, ext_zone7_chip_select, ext_write_cycle} = {20{lvl}};
    assign ext_data_line_out = {5{lvl}};
    assign ext_data_line_oe  = {5{lvl}};
endmodule

// ### dv/pbm_checker.sv
// bus handshake and input routing checks on the mux top ports
// assumes binding into pbm_top; consumer inputs idle at 1 or 0 when deselected
`timescale 1ns/1ps
module pbm_checker (
    // clock and reset
    input wire logic                      clk, sys_rst, clk_en,
    // wishbone
    input wire logic                      wb_cyc_i, wb_stb_i, wb_ack_o,
    // pads and consumer inputs
    input wire logic [pbm_pkg::NPIN-1:0]  pad_in,
    input wire logic                      i2c_data_line_in, i2c_clock_line_in, serial_a_receive,
    input wire logic                      serial_c_receive, ext_ready_input, pwm_sync_in,
    input wire logic [4:0]                ext_data_line_in
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ack_one_cycle_a:
        assert property (wb_ack_o && clk_en |=> !wb_ack_o) else $error("ack held past one cycle");
    ack_answers_a:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o) else $error("ack missing");
    ack_has_cause_a:
        assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    sda_route_a:
        assert property ($past(clk_en) && !i2c_data_line_in |-> !$past(pad_in[0])) else $error("i2c data route");
    scl_route_a:
        assert property ($past(clk_en) && !i2c_clock_line_in |-> !$past(pad_in[1])) else $error("i2c clock route");
    rx_a_route_a:
        assert property ($past(clk_en) && !serial_a_receive |-> !$past(pad_in[4])) else $error("serial a route");
    rx_c_route_a:
        assert property ($past(clk_en) && !serial_c_receive |-> !$past(pad_in[9])) else $error("serial c route");
    ready_route_a:
        assert property ($past(clk_en) && !ext_ready_input |-> !$past(pad_in[2])) else $error("ready route");
    sync_in_route_a:
        assert property ($past(clk_en) && pwm_sync_in |-> $past(pad_in[0])) else $error("sync input route");
    data16_route_a:
        assert property ($past(clk_en) && ext_data_line_in[0] |-> $past(pad_in[10])) else $error("data line route");
endmodule
bind pbm_top pbm_checker chk (.*);

// ### dv/test_pbm_top.sv
// self-checking bench: register access, then every select code on every pad
// assumes the peripheral stand-in drives all sources from lvl, gpio from ~lvl
`timescale 1ns/1ps
module test_pbm_top;
    logic        clk = 0, sys_rst = 1, clk_en = 1, lvl = 0;
    logic [3:0]  wb_adr_i = 0, wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
    logic        wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_ack_o;
    logic [pbm_pkg::NPIN-1:0] pad_in, pad_out, pad_oe, gpio_out, gpio_oe, gpio_in;
    logic capture_unit_1_io_out, capture_unit_1_io_oe, capture_unit_1_io_in;
    logic capture_unit_2_io_out, capture_unit_2_io_oe, capture_unit_2_io_in;
    logic serial_a_transmit, serial_a_receive, serial_c_transmit, serial_c_receive;
    logic i2c_clock_line_drive_low, i2c_clock_line_in, i2c_data_line_drive_low, i2c_data_line_in;
    logic pwm_sync_out, pwm_sync_in, adc_start_a_out, adc_start_b_out;
    logic bsp_a_rx_frame_sync_out, bsp_a_rx_frame_sync_oe, bsp_a_rx_frame_sync_in;
    logic bsp_b_rx_frame_sync_out, bsp_b_rx_frame_sync_oe, bsp_b_rx_frame_sync_in;
    logic bsp_b_rx_clock_out, bsp_b_rx_clock_oe, bsp_b_rx_clock_in;
    logic ext_zone0_chip_select, ext_zone7_chip_select, ext_write_cycle, ext_ready_input;
    logic [4:0] ext_data_line_out, ext_data_line_oe, ext_data_line_in;
    int   err_count = 0, compares = 0;
    // per pad, codes 00..11: G gpio, D open drain, I input only, O output, B bidir, W strobe
    string kind [11] = '{"GDIO", "GDOO", "GBII", "GOWW", "GIOO", "GBOO", "GBBB", "GBBB", "GBBB", "GIBB", "GOBB"};
    byte  k;
    logic [1:0] e;
    assign pad_in = {pbm_pkg::NPIN{lvl}};
    always #2.5 clk = ~clk;
    pbm_top dut (.*);
    pbm_periph_model model (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // classic single cycle; no fixed latency assumed, only the watchdog ends a hang
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
        wb_adr_i <= a;
        wb_we_i  <= w;
        wb_dat_i <= d;
        wb_sel_i <= s;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        @(posedge clk);
        while (wb_ack_o !== 1'b1)
            @(posedge clk);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [1:0] pad_exp(input byte kd, input logic v);
        case (kd)
            "G": return {~v, ~v};
            "D": return {1'b0, v};
            "B": return {v, v};
            "W": return {~v, 1'b1};
            "O": return {v, 1'b1};
            default: return 2'b00;
        endcase
    endfunction
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #20us;
        err_count++;
        report_and_stop();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        wb(pbm_pkg::ADR_LOW, 0, 0, 4'hF);
        chk(rd, pbm_pkg::LOW_RST);
        wb(pbm_pkg::ADR_HIGH, 0, 0, 4'hF);
        chk(rd, pbm_pkg::HIGH_RST);
        wb(4'hC, 1, 32'hFFFFFFFF, 4'hF);
        chk(rd, 32'h0);
        wb(pbm_pkg::ADR_LOW, 1, 32'hFFFFFFFF, 4'hF);
        wb(pbm_pkg::ADR_LOW, 0, 0, 4'hF);
        chk(rd, pbm_pkg::LOW_MASK);
        wb(pbm_pkg::ADR_HIGH, 1, 32'hFFFFFFFF, 4'h8);
        wb(pbm_pkg::ADR_HIGH, 0, 0, 4'hF);
        chk(rd, pbm_pkg::HIGH_MASK & 32'hFF000000);
        $display("test register access done");
        for (int c = 0; c < 4; c++)
        begin
            wb(pbm_pkg::ADR_LOW, 1, {20'h0, {6{c[1:0]}}}, 4'hF);
            wb(pbm_pkg::ADR_HIGH, 1, {{5{c[1:0]}}, 22'h0}, 4'hF);
            for (int v = 0; v < 2; v++)
            begin
                lvl <= v[0];
                repeat (3) @(posedge clk);
                for (int p = 0; p < pbm_pkg::NPIN; p++)
                begin
                    k = kind[p][c];
                    e = pad_exp(k, v[0]);
                    chk(pad_oe[p], e[0]);
                    if (k != "I")
                        chk(pad_out[p], e[1]);
                    chk(gpio_in[p], (c == 0) ? v : 0);
                end
                chk(serial_a_receive, (c == 1) ? v : 1);
                chk(i2c_data_line_in, (c == 1) ? v : 1);
                chk(ext_ready_input, (c > 1) ? v : 1);
                chk(pwm_sync_in, (c == 2) ? v : 0);
                chk(capture_unit_1_io_in, (c == 1) ? v : 0);
                chk(capture_unit_2_io_in, (c == 1) ? v : 0);
                chk(serial_c_receive, (c == 1) ? v : 1);
                chk(i2c_clock_line_in, (c == 1) ? v : 1);
                chk(bsp_a_rx_frame_sync_in, (c == 1) ? v : 0);
                chk(bsp_b_rx_clock_in, (c == 1) ? v : 0);
                chk(bsp_b_rx_frame_sync_in, (c == 1) ? v : 0);
                chk(ext_data_line_in, (c > 1) ? {5{v[0]}} : 5'h00);
                wb(pbm_pkg::ADR_LEVEL, 0, 0, 4'hF);
                chk(rd, {21'h0, {pbm_pkg::NPIN{v[0]}}});
            end
            $display("test select code %0d done", c);
        end
        // frozen state must ignore the pad change until the enable returns
        clk_en <= 1'b0;
        lvl    <= 1'b0;
        repeat (3) @(posedge clk);
        chk(ext_data_line_in, 5'h1F);
        clk_en <= 1'b1;
        repeat (3) @(posedge clk);
        chk(ext_data_line_in, 5'h00);
        $display("test clock enable freeze done");
        sys_rst <= 1'b1;
        @(posedge clk);
        chk(ext_ready_input, 1);
        sys_rst <= 1'b0;
        @(posedge clk);
        wb(pbm_pkg::ADR_LOW, 0, 0, 4'hF);
        chk(rd, pbm_pkg::LOW_RST);
        wb(pbm_pkg::ADR_HIGH, 0, 0, 4'hF);
        chk(rd, pbm_pkg::HIGH_RST);
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule
